// ==== bench/multi_event_readout_buffer_test.sv ====
// Self-checking bench for the readout buffer.
`timescale 1ns/100ps
// ======================================================================
// Bench top
module multi_event_readout_buffer_test;
  logic        clk, srst, rd_pulse, abort_in, cal_in, scal_in, fast_clear_window;
  logic        cmd_test, cmd_trig, cmd_abort, reg_rd, as_n, go, slow;
  logic [3:0]  mbusy, mnodata, tag;
  logic [7:0]  gate_w, pulse_w, cal_sp, reg_addr, scal_val;
  logic [1:0]  sid;
  logic [15:0] sdata;
  logic        svalid, sdone, t_gate, t_clr, t_pls, busy, fec, ccard;
  logic        nodata, dnodata;
  logic [31:0] rdata;
  logic [4:0]  cnt [4];
  int          err_count, cmp_count;

  readout_buffer dut_u (
    .CLK(clk), .SRST(srst), .READOUT_PULSE(rd_pulse), .ABORT_IN(abort_in),
    .CAL_IN(cal_in), .SCALER_COUNT_INPUT(scal_in), .FAST_CLEAR_WINDOW(fast_clear_window),
    .MODULE_BUSY(mbusy), .MODULE_NO_DATA(mnodata), .CMD_TEST(cmd_test),
    .CMD_TRIGGER(cmd_trig), .CMD_ABORT(cmd_abort), .GATE_WIDTH(gate_w),
    .PULSE_WIDTH(pulse_w), .CAL_SPACING(cal_sp), .HEADER_TAG(tag),
    .STREAM_ID(sid), .STREAM_DATA(sdata), .STREAM_VALID(svalid),
    .STREAM_DONE(sdone), .REG_ADDR(reg_addr), .REG_RD(reg_rd), .AS_N(as_n),
    .REG_RDATA(rdata), .TEST_GATE_OUT(t_gate), .TEST_CLEAR_OUT(t_clr),
    .TEST_PULSE_OUT(t_pls), .BUSY_OUT(busy), .FRONT_END_CLEAR_PULSE(fec),
    .CAL_CARD_PULSE(ccard), .NO_DATA_FLAG(nodata),
    .DRIVER_NO_DATA(dnodata), .SCALER_VALUE(scal_val));

  stream_source src_u (
    .CLK(clk), .GO(go), .SLOW(slow), .COUNT(cnt), .STREAM_ID(sid),
    .STREAM_DATA(sdata), .STREAM_VALID(svalid), .STREAM_DONE(sdone));

  // ====================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bounded wait for a level, then compared.
  task automatic wait_sig(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++)
      @(negedge clk);
    check(s, v);
  endtask : wait_sig

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask : pulse

  // Counts high cycles, the first sample taken on entry.
  task automatic count_high(ref logic s, input int span, output int n);
    n = int'(s);
    repeat (span - 1) begin
      @(negedge clk);
      n += int'(s);
    end
  endtask : count_high

  // One register read; the answer is taken one cycle after the read edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge clk);
    d = rdata;
    reg_rd = 1'h0;
  endtask : rd

  task automatic readout(input int c [4], input logic s);
    foreach (cnt[i]) cnt[i] = 5'(c[i]);
    slow = s;
    @(negedge clk);
    rd_pulse = 1'h1;
    cyc(3);
    rd_pulse = 1'h0;
    cyc(5);
    pulse(go);
  endtask : readout

  task automatic read_event(input int p, input int c [4]);
    logic [31:0] d;
    logic [15:0] h;
    h = {tag, 4'(p), 8'(c[0] + c[1] + c[2] + c[3] + 1)};
    wait_sig(nodata, 1'h0);
    check(dnodata, 1'h0);
    mnodata = 4'h1;
    cyc(2);
    check(dnodata, 1'h1);
    mnodata = 4'h0;
    rd(8'h34, d);
    check(d[15:0], h);
    check(nodata, 1'h0);
    as_n = 1'h0;
    rd(8'h20, d);
    check(d[15:0], h);
    check(nodata, 1'h1);
    for (int s = 0; s < 4; s++)
      for (int n = 0; n < c[s]; n++) begin
        rd(8'h20, d);
        check(d[15:0], {4'(s), 4'h0, 8'(n)});
      end
  endtask : read_event

  // ====================================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    check({nodata, dnodata, busy}, 3'h6);
    rd(8'h10, d);
    check(d, 32'h0);
    rd(8'h20, d);
    check(d[15:0], 16'hFFFF);
    $display("reset test done");
  endtask : t_reset

  task automatic t_event;
    logic [31:0] d;
    readout('{2, 3, 1, 0}, 1'h0);
    check(busy, 1'h1);
    wait_sig(busy, 1'h0);
    readout('{20, 1, 0, 2}, 1'h1);
    wait_sig(busy, 1'h0);
    read_event(0, '{2, 3, 1, 0});
    rd(8'h20, d);
    check(d[15:0] !== 16'hA118, 1'h1);
    as_n = 1'h1;
    cyc(2);
    read_event(1, '{20, 1, 0, 2});
    as_n = 1'h1;
    $display("event test done");
  endtask : t_event

  task automatic t_fcw;
    fast_clear_window = 1'h1;
    cyc(3);
    readout('{1, 1, 0, 0}, 1'h0);
    cyc(20);
    check({busy, fec}, 2'h3);
    abort_in = 1'h1;  // Late in the window, so it must count.
    cyc(5);
    check(t_clr, 1'h1);
    abort_in = 1'h0;
    cyc(3);
    fast_clear_window = 1'h0;
    wait_sig(busy, 1'h0);
    cyc(30);
    check(nodata, 1'h1);
    $display("window test done");
  endtask : t_fcw

  task automatic t_cmds;
    int n, m;
    logic pg;
    pulse(cmd_test);
    count_high(t_gate, 8, n);
    check(n, 3);
    pulse(cmd_trig);
    count_high(t_pls, 8, n);
    check(n, 4);
    pulse(cmd_abort);
    count_high(t_clr, 4, n);
    check(n != 0, 1'h1);
    cyc(6);
    abort_in = 1'h1;
    count_high(fec, 10, n);
    abort_in = 1'h0;
    check(n, 3);
    cal_in = 1'h1;
    n = 0;
    m = 0;
    pg = 1'h0;
    repeat (300) begin
      @(negedge clk);
      n += int'(t_gate & ~pg);
      pg = t_gate;
      m += int'(ccard);
    end
    cal_in = 1'h0;
    check({n >= 2, m != 0}, 2'h3);
    $display("command test done");
  endtask : t_cmds

  task automatic t_misc;
    logic [7:0] v;
    v = scal_val;
    repeat (5) begin
      scal_in = 1'h1;
      cyc(3);
      scal_in = 1'h0;
      cyc(3);
    end
    cyc(4);
    check(scal_val, 8'(v + 8'h05));
    mbusy = 4'h4;
    cyc(2);
    check(busy, 1'h1);
    mbusy = 4'h0;
    $display("scaler and busy test done");
  endtask : t_misc

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ====================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    {srst, rd_pulse, abort_in, cal_in, scal_in, fast_clear_window} = 6'h20;
    {cmd_test, cmd_trig, cmd_abort, reg_rd, as_n, go, slow} = 7'h04;
    {mbusy, mnodata, tag} = 12'h00A;
    {gate_w, pulse_w, cal_sp, reg_addr} = 32'h03040500;
    foreach (cnt[i]) cnt[i] = 5'h00;
    err_count = 0;
    cmp_count = 0;
    cyc(4);
    srst = 1'h0;
    cyc(3);
    t_reset();
    t_event();
    t_fcw();
    t_cmds();
    t_misc();
    stop_test();
  end
endmodule : multi_event_readout_buffer_test

// ==== bench/readout_buffer_properties.sv ====
// Port-level concurrent checks for the readout buffer.
`timescale 1ns/100ps
// ======================================================================
// Checker
module readout_checker (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       ABORT_IN,
  input wire logic       CAL_IN,
  input wire logic [3:0] MODULE_BUSY,
  input wire logic [3:0] MODULE_NO_DATA,
  input wire logic       CMD_TEST,
  input wire logic       CMD_TRIGGER,
  input wire logic       CMD_ABORT,
  input wire logic [7:0] GATE_WIDTH,
  input wire logic [7:0] PULSE_WIDTH,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic       TEST_GATE_OUT,
  input wire logic       TEST_CLEAR_OUT,
  input wire logic       TEST_PULSE_OUT,
  input wire logic       BUSY_OUT,
  input wire logic       NO_DATA_FLAG,
  input wire logic       DRIVER_NO_DATA,
  input wire logic [7:0] SCALER_VALUE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Wired-OR lines from the other modules reach the shared outputs.
  property p_busy_or; |MODULE_BUSY |=> BUSY_OUT; endproperty
  a_busy_or: assert property (p_busy_or) else $error("busy not ored");
  property p_nodata_or; |MODULE_NO_DATA |=> DRIVER_NO_DATA; endproperty
  a_nodata_or: assert property (p_nodata_or)
    else $error("no-data not ored");

  // Software commands produce their pulses; test pulse and gate with programmed widths 4 and 3.
  property p_cmd_clear; CMD_ABORT |-> ##[1:2] TEST_CLEAR_OUT; endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("no clear");
  property p_pulse_width;
    CMD_TRIGGER && PULSE_WIDTH == 8'h04
      |=> ##1 TEST_PULSE_OUT [*4] ##1 !TEST_PULSE_OUT;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("test pulse width wrong");
  property p_gate_width;
    CMD_TEST && GATE_WIDTH == 8'h03 && !CAL_IN && !TEST_GATE_OUT
      |=> ##1 TEST_GATE_OUT [*3] ##1 !TEST_GATE_OUT;
  endproperty
  a_gate_width: assert property (p_gate_width)
    else $error("gate width wrong");

  // The data port consumes the header, the peek location does not.
  property p_hdr_read;
    REG_RD && REG_ADDR == 8'h20 && !NO_DATA_FLAG |=> NO_DATA_FLAG;
  endproperty
  a_hdr_read: assert property (p_hdr_read) else $error("flag kept");
  property p_peek_keep;
    (!ABORT_IN && !CMD_ABORT) [*4] ##0
      (REG_RD && REG_ADDR == 8'h34 && !NO_DATA_FLAG) |=> !NO_DATA_FLAG;
  endproperty
  a_peek_keep: assert property (p_peek_keep)
    else $error("peek consumed header");

  // Reset state and the scaler stepping by one.
  property p_reset_state;
    $fell(SRST) |-> NO_DATA_FLAG && DRIVER_NO_DATA && !BUSY_OUT;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad reset state");
  property p_scaler_step;
    SCALER_VALUE != $past(SCALER_VALUE)
      |-> SCALER_VALUE == 8'($past(SCALER_VALUE) + 8'h01);
  endproperty
  a_scaler_step: assert property (p_scaler_step)
    else $error("scaler jumped");

  // Main scenarios seen.
  c_hdr: cover property (REG_RD && REG_ADDR == 8'h20 && !NO_DATA_FLAG);
  c_cal: cover property (CAL_IN && TEST_GATE_OUT);
  c_trig: cover property (CMD_TRIGGER && PULSE_WIDTH == 8'h04);
endmodule : readout_checker

bind readout_buffer readout_checker chk_u (
  .CLK(CLK), .SRST(SRST), .ABORT_IN(ABORT_IN), .CAL_IN(CAL_IN),
  .MODULE_BUSY(MODULE_BUSY), .MODULE_NO_DATA(MODULE_NO_DATA),
  .CMD_TEST(CMD_TEST), .CMD_TRIGGER(CMD_TRIGGER), .CMD_ABORT(CMD_ABORT),
  .GATE_WIDTH(GATE_WIDTH), .PULSE_WIDTH(PULSE_WIDTH), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .TEST_GATE_OUT(TEST_GATE_OUT),
  .TEST_CLEAR_OUT(TEST_CLEAR_OUT), .TEST_PULSE_OUT(TEST_PULSE_OUT),
  .BUSY_OUT(BUSY_OUT), .NO_DATA_FLAG(NO_DATA_FLAG),
  .DRIVER_NO_DATA(DRIVER_NO_DATA), .SCALER_VALUE(SCALER_VALUE));

// ==== bench/stream_source.sv ====
// Model of the zero-suppressed stream side feeding the buffer.
`timescale 1ns/100ps
// ======================================================================
// Stream source
module stream_source (
  input  wire logic        CLK,
  input  wire logic        GO,
  input  wire logic        SLOW,
  input  wire logic [4:0]  COUNT [4],
  output logic      [1:0]  STREAM_ID,
  output logic      [15:0] STREAM_DATA,
  output logic             STREAM_VALID,
  output logic             STREAM_DONE
);
  int sent [4];

  // Lines start idle.
  initial begin
    STREAM_ID    = 2'h0;
    STREAM_DATA  = 16'h0000;
    STREAM_VALID = 1'h0;
    STREAM_DONE  = 1'h0;
  end

  // Each start plays the streams round robin, one word per visit.
  always begin
    @(posedge CLK iff GO);
    sent = '{default: 0};
    for (int r = 0; r < 32; r++) begin
      for (int s = 0; s < 4; s++) begin
        if (sent[s] < int'(COUNT[s])) begin
          @(negedge CLK);
          STREAM_ID    = 2'(s);
          STREAM_DATA  = {4'(s), 4'h0, 8'(sent[s])};
          STREAM_VALID = 1'h1;
          sent[s]++;
          @(negedge CLK);
          STREAM_VALID = 1'h0;
          STREAM_DATA  = ~STREAM_DATA;  // No stale word is left shown.
          if (SLOW)
            repeat (2) @(negedge CLK);
        end
      end
    end
    @(negedge CLK);
    STREAM_DONE = 1'h1;
    @(negedge CLK);
    STREAM_DONE = 1'h0;
  end
endmodule : stream_source

// ==== hdl/event_fifo.sv ====
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module event_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             CLK,
  input  wire logic             SRST,
  input  wire logic             CLR,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic      [WIDTH-1:0] OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;

  // ======================================================================
  // Pointer update; full and empty come from the extra wrap bit.
  always_comb begin
    push     = IN_VALID && IN_READY;
    pop      = OUT_VALID && OUT_READY;
    wp_d     = CLR ? '0 : wp_q + (AW+1)'(push);
    rp_d     = CLR ? '0 : rp_q + (AW+1)'(pop);
    IN_READY = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    OUT_VALID = (wp_q != rp_q);
    OUT_DATA = mem[rp_q[AW-1:0]];
  end

  // Registers the pointers and stores pushed words.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem[wp_q[AW-1:0]] <= IN_DATA;
    end
  end
endmodule : event_fifo

// ==== hdl/readout_buffer.sv ====
// Multi-event buffer, readout control and trigger-side driver logic.
// Operation
// - Readout trigger edge starts a stream readout; input held at least 100 ns.
// - Abort stops readout, clears waiting event, pulses front-end clear.
// - Calibrate active emits gate pulse pairs near 100 kHz with card pulses.
// - Scaler input edges count in a readable 8-bit counter.
// - Fast clear window before readout end holds commit and busy, clears front.
// - Abort accepted from 500 ns after readout pulse until window end.
// - Two events never join in one transfer while AS_N stays low.
// - Busy output is the OR of all module busy lines.
// - Test clear output follows abort input or internal abort command.
// - Test command gives one gate pulse; calibration pairs share the output.
// - Trigger command gives a programmable-width test pulse at once.
// - Memory holds 16 pages of four 32-word 16-bit segments.
// - Readout writes stream data round robin into a free page's segments.
// - Clean completion stores counts, advances write pointer, drops busy.
// - With 15 of 16 pages holding events busy stays until the copy engine has moved an event into the output FIFO.
// - Buffered event copies to output FIFO in stream order 0 to 3.
// - First word is a header with page, word count and user identifier.
// - Header count is sum of stream counts plus one, in 16-bit words.
// - No-data flag clears with fresh event, sets when header read.
// - Driver no-data flag is the OR of all module flags.
// - Peek offset returns header without consuming; gone once header read.
// - Data read with no event returns 0xFFFF in low 16 bits.
`timescale 1ns/100ps
`include "readout_regs.svh"
module readout_buffer (
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Trigger-side pins.
  input  wire logic        READOUT_PULSE,
  input  wire logic        ABORT_IN,
  input  wire logic        CAL_IN,
  input  wire logic        SCALER_COUNT_INPUT,
  input  wire logic        FAST_CLEAR_WINDOW,
  input  wire logic [3:0]  MODULE_BUSY,
  input  wire logic [3:0]  MODULE_NO_DATA,
  // Software commands and settings.
  input  wire logic        CMD_TEST,
  input  wire logic        CMD_TRIGGER,
  input  wire logic        CMD_ABORT,
  input  wire logic [7:0]  GATE_WIDTH,
  input  wire logic [7:0]  PULSE_WIDTH,
  input  wire logic [7:0]  CAL_SPACING,
  input  wire logic [3:0]  HEADER_TAG,
  // Stream data from the zero-suppressor.
  input  wire logic [1:0]  STREAM_ID,
  input  wire logic [15:0] STREAM_DATA,
  input  wire logic        STREAM_VALID,
  input  wire logic        STREAM_DONE,
  // Register port.
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_RD,
  input  wire logic        AS_N,
  output logic      [31:0] REG_RDATA,
  // Outputs.
  output logic             TEST_GATE_OUT,
  output logic             TEST_CLEAR_OUT,
  output logic             TEST_PULSE_OUT,
  output logic             BUSY_OUT,
  output logic             FRONT_END_CLEAR_PULSE,
  output logic             CAL_CARD_PULSE,
  output logic             NO_DATA_FLAG,
  output logic             DRIVER_NO_DATA,
  output logic      [7:0]  SCALER_VALUE
);
  // ======================================================================
  // Pin synchronisers: two flops before logic reads a trigger pin; the module busy and no-data lines are read unsynchronised.
  logic [4:0] s1_q, s2_q, s3_q;
  always_ff @(posedge CLK) begin
    s1_q <= {READOUT_PULSE, ABORT_IN, CAL_IN, SCALER_COUNT_INPUT,
             FAST_CLEAR_WINDOW};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  logic rd_edge, abort_lvl, cal_lvl, scl_edge, fcw_lvl, as_rise;
  logic [1:0] as_q;
  always_ff @(posedge CLK) as_q <= {as_q[0], AS_N};
  assign rd_edge   = s2_q[4] && !s3_q[4];
  assign abort_lvl = s2_q[3] || CMD_ABORT;
  assign cal_lvl   = s2_q[2];
  assign scl_edge  = s2_q[1] && !s3_q[1];
  assign fcw_lvl   = s2_q[0];
  assign as_rise   = as_q[1];

  // ======================================================================
  // Event memory and housekeeping counts.
  logic [15:0] ev_mem [16*4*32];
  logic [5:0]  hk_cnt [16*4];

  function automatic logic [10:0] mem_addr(input logic [3:0] pg,
                                           input logic [1:0] st,
                                           input logic [4:0] wd);
    mem_addr = {pg, st, wd};
  endfunction : mem_addr

  // ======================================================================
  // Write side: stream readout and commit.
  readout_pkg::wr_state_t wst_q, wst_d;
  logic [3:0] wp_q, wp_d, rp_q, rp_d;
  logic [5:0] scnt_q [4];
  logic [5:0] scnt_d [4];
  logic [4:0] open_q, open_d;
  logic       ev_out, full;

  always_comb begin
    wst_d  = wst_q;
    wp_d   = wp_q;
    scnt_d = scnt_q;
    open_d = open_q;
    // One page stays unused so that equal pointers always mean empty.
    full   = (4'(wp_q + 4'h1) == rp_q);
    if (open_q != 5'h00)
      open_d = open_q - 5'h01;
    unique case (wst_q)
      readout_pkg::WR_IDLE:
        if (rd_edge) begin
          wst_d  = full ? readout_pkg::WR_FULL : readout_pkg::WR_STREAM;
          scnt_d = '{default: 6'h00};
          open_d = 5'(`ABORT_OPEN_CYC);
        end
      readout_pkg::WR_STREAM: begin
        if (STREAM_VALID && scnt_q[STREAM_ID] < 6'd32)
          scnt_d[STREAM_ID] = scnt_q[STREAM_ID] + 6'h01;
        if (abort_lvl && open_q == 5'h00)
          wst_d = readout_pkg::WR_IDLE;
        else if (STREAM_DONE)
          wst_d = fcw_lvl ? readout_pkg::WR_HOLD
                          : readout_pkg::WR_COMMIT;
      end
      readout_pkg::WR_HOLD:
        if (abort_lvl)
          wst_d = readout_pkg::WR_IDLE;
        else if (!fcw_lvl)
          wst_d = readout_pkg::WR_COMMIT;
      readout_pkg::WR_COMMIT: begin
        wp_d  = wp_q + 4'h1;
        wst_d = readout_pkg::WR_IDLE;
      end
      readout_pkg::WR_FULL:
        if (abort_lvl)
          wst_d = readout_pkg::WR_IDLE;
        else if (!full)
          wst_d = readout_pkg::WR_STREAM;
    endcase
  end

  // Registers write state; stores data words and commits counts.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wst_q  <= readout_pkg::WR_IDLE;
      wp_q   <= 4'h0;
      scnt_q <= '{default: 6'h00};
      open_q <= 5'h00;
    end else begin
      wst_q  <= wst_d;
      wp_q   <= wp_d;
      scnt_q <= scnt_d;
      open_q <= open_d;
    end
    if (wst_q == readout_pkg::WR_STREAM && STREAM_VALID &&
        scnt_q[STREAM_ID] < 6'd32)
      ev_mem[mem_addr(wp_q, STREAM_ID, scnt_q[STREAM_ID][4:0])] <=
        STREAM_DATA;
    if (wst_q == readout_pkg::WR_COMMIT)
      for (int i = 0; i < 4; i++)
        hk_cnt[{wp_q, 2'(i)}] <= scnt_q[i];
  end

  // ======================================================================
  // Copy engine: page to output FIFO with a leading header.
  readout_pkg::cp_state_t cst_q, cst_d;
  logic [1:0]  cs_q, cs_d;
  logic [5:0]  cw_q, cw_d;
  logic        pend_q, pend_d;     // Event in FIFO not fully read.
  logic [15:0] hdr_q, hdr_d;
  logic        hdr_ok_q, hdr_ok_d;
  logic [15:0] f_in, f_out;
  logic        f_in_v, f_in_r, f_out_v, f_out_r, f_clr;
  logic [7:0]  total;
  logic        data_rd, peek_rd, flush;

  always_comb begin
    total = 8'(hk_cnt[{rp_q, 2'd0}]) + 8'(hk_cnt[{rp_q, 2'd1}]) +
            8'(hk_cnt[{rp_q, 2'd2}]) + 8'(hk_cnt[{rp_q, 2'd3}]) +
            8'h01;
  end

  assign data_rd = REG_RD && REG_ADDR == `OFS_DATA_PORT;
  assign peek_rd = REG_RD && REG_ADDR == `OFS_HDR_PEEK;
  assign ev_out  = (rp_q != wp_q);
  assign flush   = abort_lvl && pend_q;

  always_comb begin
    cst_d    = cst_q;
    cs_d     = cs_q;
    cw_d     = cw_q;
    rp_d     = rp_q;
    pend_d   = pend_q;
    hdr_d    = hdr_q;
    hdr_ok_d = hdr_ok_q;
    f_in     = 16'h0000;
    f_in_v   = 1'b0;
    unique case (cst_q)
      readout_pkg::CP_IDLE:
        if (ev_out && !pend_q) begin
          cst_d = readout_pkg::CP_HEAD;
          hdr_d = 16'(total[`HDR_CNT_W-1:0]) |
                  (16'(rp_q) << `HDR_PAGE_LSB) |
                  (16'(HEADER_TAG) << `HDR_ID_LSB);
        end
      readout_pkg::CP_HEAD: begin
        f_in   = hdr_q;
        f_in_v = 1'b1;
        if (f_in_r) begin
          cst_d    = readout_pkg::CP_DATA;
          pend_d   = 1'b1;
          hdr_ok_d = 1'b1;
          cs_d     = 2'd0;
          cw_d     = 6'h00;
        end
      end
      readout_pkg::CP_DATA:
        if (cw_q >= hk_cnt[{rp_q, cs_q}]) begin
          cw_d = 6'h00;
          cs_d = cs_q + 2'd1;
          if (cs_q == 2'd3) begin
            cst_d = readout_pkg::CP_IDLE;
            rp_d  = rp_q + 4'h1;
          end
        end else begin
          f_in   = ev_mem[mem_addr(rp_q, cs_q, cw_q[4:0])];
          f_in_v = 1'b1;
          if (f_in_r)
            cw_d = cw_q + 6'h01;
        end
      default: cst_d = readout_pkg::CP_IDLE;
    endcase
    if (data_rd && hdr_ok_q)
      hdr_ok_d = 1'b0;
    // Event ends only when the copy is done, the FIFO has drained and
    // AS_N, seen two cycles late, is high; a block read that runs past the
    // end sees the empty word and never the next event's header.
    if (pend_q && cst_q == readout_pkg::CP_IDLE && !hdr_ok_q &&
        (!f_out_v && as_rise))
      pend_d = 1'b0;
    if (flush) begin
      cst_d    = readout_pkg::CP_IDLE;
      pend_d   = 1'b0;
      hdr_ok_d = 1'b0;
      if (cst_q != readout_pkg::CP_IDLE)
        rp_d = rp_q + 4'h1;
    end
  end

  assign f_clr   = flush || (!pend_q && cst_q == readout_pkg::CP_IDLE);
  assign f_out_r = data_rd;

  // Registers copy engine state.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cst_q    <= readout_pkg::CP_IDLE;
      cs_q     <= 2'd0;
      cw_q     <= 6'h00;
      rp_q     <= 4'h0;
      pend_q   <= 1'b0;
      hdr_q    <= 16'h0000;
      hdr_ok_q <= 1'b0;
    end else begin
      cst_q    <= cst_d;
      cs_q     <= cs_d;
      cw_q     <= cw_d;
      rp_q     <= rp_d;
      pend_q   <= pend_d;
      hdr_q    <= hdr_d;
      hdr_ok_q <= hdr_ok_d;
    end
  end

  event_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .CLK      (CLK),
    .SRST     (SRST),
    .CLR      (f_clr),
    .IN_DATA  (f_in),
    .IN_VALID (f_in_v),
    .IN_READY (f_in_r),
    .OUT_DATA (f_out),
    .OUT_VALID(f_out_v),
    .OUT_READY(f_out_r)
  );

  // ======================================================================
  // Driver pulse timers.
  logic [7:0]  gate_q, gate_d, pls_q, pls_d, gap_q, gap_d, scl_q, scl_d;
  logic [8:0]  cal_q, cal_d;
  logic [2:0]  fec_q, fec_d;
  logic        abort_prev_q;

  always_comb begin
    gate_d = (gate_q != 8'h00) ? gate_q - 8'h01 : 8'h00;
    pls_d  = (pls_q  != 8'h00) ? pls_q  - 8'h01 : 8'h00;
    gap_d  = (gap_q  != 8'h00) ? gap_q  - 8'h01 : 8'h00;
    cal_d  = (cal_q  != 9'h000) ? cal_q - 9'h001 : 9'(`CAL_PERIOD_CYC - 1);
    fec_d  = (fec_q  != 3'h0) ? fec_q  - 3'h1 : 3'h0;
    scl_d  = scl_q + 8'(scl_edge);
    if (CMD_TEST)
      gate_d = GATE_WIDTH;
    if (CMD_TRIGGER)
      pls_d = PULSE_WIDTH;
    if (!cal_lvl)
      cal_d = 9'h000;
    else if (cal_q == 9'h000) begin
      gate_d = 8'h01;
      gap_d  = CAL_SPACING;
    end
    if (cal_lvl && gap_q == 8'h01)
      gate_d = 8'h01;
    if (abort_lvl && !abort_prev_q)
      fec_d = 3'(`FEC_CYC);
  end

  // Registers the timers and drives the flopped outputs.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gate_q                <= 8'h00;
      pls_q                 <= 8'h00;
      gap_q                 <= 8'h00;
      scl_q                 <= 8'h00;
      cal_q                 <= 9'h000;
      fec_q                 <= 3'h0;
      abort_prev_q          <= 1'b0;
      TEST_GATE_OUT         <= 1'b0;
      TEST_CLEAR_OUT        <= 1'b0;
      TEST_PULSE_OUT        <= 1'b0;
      BUSY_OUT              <= 1'b0;
      FRONT_END_CLEAR_PULSE <= 1'b0;
      CAL_CARD_PULSE        <= 1'b0;
      NO_DATA_FLAG          <= 1'b1;
      DRIVER_NO_DATA        <= 1'b1;
      SCALER_VALUE          <= 8'h00;
      REG_RDATA             <= 32'h0000_0000;
    end else begin
      gate_q       <= gate_d;
      pls_q        <= pls_d;
      gap_q        <= gap_d;
      scl_q        <= scl_d;
      cal_q        <= cal_d;
      fec_q        <= fec_d;
      abort_prev_q <= abort_lvl;
      TEST_GATE_OUT  <= gate_q != 8'h00;
      TEST_CLEAR_OUT <= abort_lvl;
      TEST_PULSE_OUT <= pls_q != 8'h00;
      BUSY_OUT <= (|MODULE_BUSY) || (wst_q != readout_pkg::WR_IDLE);
      FRONT_END_CLEAR_PULSE <= fec_q != 3'h0 ||
                               wst_q == readout_pkg::WR_HOLD;
      CAL_CARD_PULSE <= cal_lvl && (cal_q == 9'h001 || gap_q == 8'h01);
      NO_DATA_FLAG   <= !(hdr_ok_d && f_out_v);
      DRIVER_NO_DATA <= (|MODULE_NO_DATA) ||
                        !(hdr_ok_d && f_out_v);
      SCALER_VALUE   <= scl_q;
      if (data_rd)
        REG_RDATA <= {16'h0000, f_out_v ? f_out : `EMPTY_WORD};
      else if (peek_rd)
        REG_RDATA <= {16'h0000, hdr_ok_q ? hdr_q : `EMPTY_WORD};
      else
        REG_RDATA <= 32'h0000_0000;
    end
  end
endmodule : readout_buffer

// ==== hdl/readout_pkg.sv ====
// Types shared by the readout buffer design.
package readout_pkg;
  typedef enum logic [2:0] {
    WR_IDLE, WR_STREAM, WR_HOLD, WR_COMMIT, WR_FULL
  } wr_state_t;
  typedef enum logic [1:0] {
    CP_IDLE, CP_HEAD, CP_DATA
  } cp_state_t;
  typedef logic [15:0] word_t;
endpackage : readout_pkg

// ==== hdl/readout_regs.svh ====
// Register offsets, field positions and timing counts of the readout buffer.
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH
// ======================================================================
// Register offsets
`define OFS_DATA_PORT   8'h20
`define OFS_HDR_PEEK    8'h34
// ======================================================================
// Geometry
`define PAGE_AW         4
`define SEG_AW          5
`define WORD_W          16
`define FIFO_DEPTH      16
`define EMPTY_WORD      16'hFFFF
// ======================================================================
// Header fields
`define HDR_CNT_LSB     0
`define HDR_CNT_W       8
`define HDR_PAGE_LSB    8
`define HDR_ID_LSB      12
// ======================================================================
// Timing (25 MHz clock, 40 ns period)
`define CLK_NS          40
`define MIN_PULSE_NS    100
`define MIN_PULSE_CYC   ((`MIN_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define ABORT_OPEN_NS   500
`define ABORT_OPEN_CYC  ((`ABORT_OPEN_NS + `CLK_NS - 1) / `CLK_NS)
`define CAL_PERIOD_NS   10000
`define CAL_PERIOD_CYC  (`CAL_PERIOD_NS / `CLK_NS)
`define FEC_CYC         3
`endif
